// >>> verilog/omc_pkg.sv
// constants, types and register map of the fuse mirror configuration loader
package omc_pkg;
    // apb register byte offsets
    localparam logic [7:0] OMC_OFS_STATUS = 8'h00;
    localparam logic [7:0] OMC_OFS_SYS_CFG = 8'h04;
    localparam logic [7:0] OMC_OFS_TEST_KEY = 8'h08;
    localparam logic [7:0] OMC_OFS_TEST_CTRL = 8'h0C;
    localparam logic [7:0] OMC_OFS_MIRROR_IDX = 8'h10;
    localparam logic [7:0] OMC_OFS_MIRROR_DATA = 8'h14;
    localparam logic [7:0] OMC_OFS_FUNC_DATA = 8'h18;
    localparam int OMC_ADDR_W = 8;
    // system_config_one bit positions
    localparam int OMC_BIT_DIAG_LEAVE = 0;
    localparam int OMC_BIT_INIT_UNLOCK = 1;
    localparam int OMC_BIT_SAFE_RELEASE = 2;
    // test control bit positions
    localparam int OMC_BIT_TEST_EXIT = 0;
    localparam int OMC_BIT_PROG_EXIT = 1;
    localparam int OMC_BIT_BURN = 2;
    // default test-mode key word, arbitrary value
    localparam logic [31:0] OMC_TEST_KEY_DEF = 32'h5A5A_C3C3;
    // reset word and sector flag patterns
    localparam logic [31:0] OMC_ZERO_WORD = 32'h0000_0000;
    localparam logic [1:0] OMC_FLAGS_NONE = 2'h0;
    localparam logic [1:0] OMC_FLAGS_FULL = 2'h3;
    // sector select codes
    localparam logic OMC_SECTOR_FIRST = 1'b0;
    localparam logic OMC_SECTOR_SECOND = 1'b1;

    // sequencer states
    typedef enum logic [2:0] {
        OMC_LOAD_REQ,
        OMC_LOAD_CAP,
        OMC_SELECT,
        OMC_RUN,
        OMC_BURN
    } omc_state_t;

    // operating mode flags, several may be set at once
    typedef struct packed {
        logic normal;
        logic diag;
        logic test;
        logic prog;
        logic init;
    } omc_mode_t;
endpackage

// >>> verilog/omc_loader.sv
// fuse sector to mirror register loader with mode control and apb slave
//
// What this block does
// RULE_01: normal mode at power-on only with grounded pin
// RULE_02: normal mode uses whole loaded configuration
// RULE_03: one fuse block split into two sectors
// RULE_04: start-up copies latest programmed sector into mirror
// RULE_05: first sector then second, never fall back
// RULE_06: refuse burning after second sector; mirror stays usable
// RULE_07: mirror read and written without limit
// RULE_08: mirror access granted only in test mode
// RULE_09: power-on restores programmed or empty mirror content
// RULE_10: test exit copies mirror into functional registers
// RULE_11: mirror loading same for empty or programmed part
// RULE_12: after exits: normal, diagnostic and init together
// RULE_13: host configures watchdog, then unlocks init exit
// RULE_14: host sends seven good answers before release; the code releases on a single safe_release write
// RULE_15: fail-safe outputs held while fault interrupt pending
// RULE_16: test mode needs programming level and valid key
// RULE_17: test exit passes through programming mode first
// RULE_18: diagnostic exit only by register bit write
// RULE_19: mirror writes outside test mode are ignored
// RULE_20: sector flags decide programmed state and load source
`timescale 1ns/1ps
module omc_loader
    import omc_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int WIDTH = 16,
    parameter logic [31:0] TEST_KEY = omc_pkg::OMC_TEST_KEY_DEF
) (
    input wire logic clk,                                  // 100 mhz clock
    input wire logic rst_n,                                // power-on reset, async, low
    input wire logic psel,                                 // apb select
    input wire logic penable,                              // apb access phase
    input wire logic pwrite,                               // apb direction
    input wire logic [omc_pkg::OMC_ADDR_W-1:0] paddr,      // apb byte address
    input wire logic [31:0] pwdata,                        // apb write data
    output logic [31:0] prdata,                            // apb read data
    output logic pready,                                   // apb ready
    output logic pslverr,                                  // apb error
    input wire logic pin_diag_level,                       // mode-entry pin at diagnostic level
    input wire logic pin_prog_level,                       // mode-entry pin at programming level
    input wire logic [1:0] fuse_flags,                     // sector programmed flags
    output logic [$clog2(DEPTH):0] fuse_rd_addr,           // fuse read {sector, word}
    input wire logic [WIDTH-1:0] fuse_rd_data,             // fuse read data
    output logic fuse_wr_en,                               // fuse burn strobe
    output logic [$clog2(DEPTH):0] fuse_wr_addr,           // fuse burn {sector, word}
    output logic [WIDTH-1:0] fuse_wr_data,                 // fuse burn data
    input wire logic fault_pending,                        // fault interrupt pending
    output omc_pkg::omc_mode_t mode,                       // current operating modes
    output logic [DEPTH*WIDTH-1:0] func_cfg,               // functional register contents
    output logic failsafe_output_n,                        // fail-safe output, low asserted
    output logic limp_home_output                          // limp-home output, high asserted
);
    import omc_pkg::*;

    // word index width; the sector bit sits just above it
    localparam int IW = $clog2(DEPTH);
    localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);

    // latest programmed sector; second wins once its flag is set
    function automatic logic latest_sector(input logic [1:0] flags);
        latest_sector = flags[1] ? OMC_SECTOR_SECOND : OMC_SECTOR_FIRST;
    endfunction

    // register address match
    function automatic logic reg_hit(input logic [OMC_ADDR_W-1:0] addr, input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    omc_state_t state;
    omc_state_t next_state;
    logic [WIDTH-1:0] mirror_mem [DEPTH];
    logic [WIDTH-1:0] func_mem [DEPTH];
    logic [IW-1:0] idx;
    logic [IW-1:0] mirror_idx;
    logic load_sector;
    logic burn_sector;
    logic fs_assert;
    logic diag_s1, diag_s2, prog_s1, prog_s2;
    logic settle_s1, settle_s2;

    // pin synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            diag_s1 <= 1'b0;
            diag_s2 <= 1'b0;
            prog_s1 <= 1'b0;
            prog_s2 <= 1'b0;
        end else begin
            diag_s1 <= pin_diag_level;
            diag_s2 <= diag_s1;
            prog_s1 <= pin_prog_level;
            prog_s2 <= prog_s1;
        end
    end

    // synchronisers restart empty at reset; this pair marks when their
    // second stage carries the true pin level, two edges after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_s1 <= 1'b0;
            settle_s2 <= 1'b0;
        end else begin
            settle_s1 <= 1'b1;
            settle_s2 <= settle_s1;
        end
    end

    // apb phase and register decode
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire hit_status = reg_hit(paddr, OMC_OFS_STATUS);
    wire hit_sys = reg_hit(paddr, OMC_OFS_SYS_CFG);
    wire hit_key = reg_hit(paddr, OMC_OFS_TEST_KEY);
    wire hit_ctrl = reg_hit(paddr, OMC_OFS_TEST_CTRL);
    wire hit_midx = reg_hit(paddr, OMC_OFS_MIRROR_IDX);
    wire hit_mdata = reg_hit(paddr, OMC_OFS_MIRROR_DATA);
    wire hit_func = reg_hit(paddr, OMC_OFS_FUNC_DATA);
    wire mapped = hit_status | hit_sys | hit_key | hit_ctrl | hit_midx | hit_mdata | hit_func;
    wire running = (state == OMC_RUN);

    // mirror access only in test mode while idle
    // also keeps the mirror steady while a burn reads it
    wire mirror_ok = mode.test && running; // [RULE_08]
    wire mirror_wr = wr && hit_mdata && mirror_ok; // [RULE_07] [RULE_19]
    wire mirror_denied = access && hit_mdata && !mirror_ok; // [RULE_08]

    // software events
    // mode exits are qualified by the mode they leave; safe_release takes effect in any mode
    wire diag_leave = wr && hit_sys && pwdata[OMC_BIT_DIAG_LEAVE] && mode.diag; // [RULE_18]
    wire init_unlock = wr && hit_sys && pwdata[OMC_BIT_INIT_UNLOCK] && mode.init;
    wire safe_release = wr && hit_sys && pwdata[OMC_BIT_SAFE_RELEASE];
    wire key_ok = wr && hit_key && (pwdata == TEST_KEY) && prog_s2 && running; // [RULE_16]
    wire test_enter = key_ok && !mode.test && !mode.prog; // [RULE_16]
    wire test_exit = wr && hit_ctrl && pwdata[OMC_BIT_TEST_EXIT] && mode.test && running; // [RULE_10]
    wire prog_exit = wr && hit_ctrl && pwdata[OMC_BIT_PROG_EXIT] && mode.prog && !mode.test; // [RULE_17]
    wire burn_req = wr && hit_ctrl && pwdata[OMC_BIT_BURN];
    wire burn_full = (fuse_flags == OMC_FLAGS_FULL);
    wire burn_go = burn_req && mode.test && running && !burn_full; // [RULE_06]
    wire burn_refused = burn_req && !burn_go; // [RULE_06]
    wire burn_done = (state == OMC_BURN) && (idx == LAST_IDX);

    // read data selection
    wire [31:0] status_word = {21'h00_0000, fs_assert, burn_sector, load_sector, fuse_flags,
                               state == OMC_RUN, mode.normal, mode.diag, mode.test, mode.prog, mode.init};
    wire [31:0] mirror_word = mirror_ok ? 32'(mirror_mem[mirror_idx]) : OMC_ZERO_WORD;
    wire [31:0] next_prdata = hit_status ? status_word :
                              hit_midx ? 32'(mirror_idx) :
                              hit_mdata ? mirror_word :
                              hit_func ? 32'(func_mem[mirror_idx]) :
                              OMC_ZERO_WORD;

    // apb answers with no wait state
    // refused accesses still complete at once and are flagged by pslverr
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || mirror_denied || burn_refused); // [RULE_06] [RULE_19]

    // read data captured in the setup cycle
    // so it already stands when the access edge samples it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= OMC_ZERO_WORD;
        end else if (setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // mirror index register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mirror_idx <= '0;
        end else if (wr && hit_midx) begin
            mirror_idx <= pwdata[IW-1:0];
        end
    end

    // sequencer next state
    // an empty part skips the fuse reads and keeps the mirror at reset zero
    always_comb begin
        next_state = state;
        case (state)
            OMC_LOAD_REQ: begin
                if (!settle_s2) begin
                    next_state = OMC_LOAD_REQ; // wait for settled pin levels [RULE_01]
                end else if (fuse_flags == OMC_FLAGS_NONE) begin
                    next_state = OMC_SELECT; // [RULE_09] [RULE_11]
                end else begin
                    next_state = OMC_LOAD_CAP;
                end
            end
            OMC_LOAD_CAP: begin
                if (idx == LAST_IDX) begin
                    next_state = OMC_SELECT;
                end else begin
                    next_state = OMC_LOAD_REQ;
                end
            end
            OMC_SELECT: next_state = OMC_RUN;
            OMC_RUN: begin
                if (burn_go) begin
                    next_state = OMC_BURN;
                end
            end
            OMC_BURN: begin
                if (burn_done) begin
                    next_state = OMC_RUN;
                end
            end
            default: next_state = OMC_LOAD_REQ;
        endcase
    end

    // sequencer state and word counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= OMC_LOAD_REQ;
            idx <= '0;
        end else begin
            state <= next_state;
            if ((state == OMC_LOAD_CAP) || (state == OMC_BURN)) begin
                idx <= idx + 1'b1;
            end else if (state != OMC_LOAD_REQ) begin
                idx <= '0;
            end
        end
    end

    // load source chosen from sector flags, latest first
    // address is registered, so the data is captured one edge later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_sector <= OMC_SECTOR_FIRST;
            fuse_rd_addr <= '0;
        end else if (state == OMC_LOAD_REQ) begin
            load_sector <= latest_sector(fuse_flags); // [RULE_04] [RULE_05] [RULE_20]
            fuse_rd_addr <= {latest_sector(fuse_flags), idx}; // [RULE_03] [RULE_04]
        end
    end

    // mirror storage: fuse load at start-up, software writes in test mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mirror_mem[i] <= '0; // [RULE_09]
            end
        end else if (state == OMC_LOAD_CAP) begin
            mirror_mem[idx] <= fuse_rd_data; // [RULE_04] [RULE_11]
        end else if (mirror_wr) begin
            mirror_mem[mirror_idx] <= pwdata[WIDTH-1:0]; // [RULE_07]
        end
    end

    // functional registers follow mirror at start-up and at test exit
    // copied whole in one edge, so no half-updated configuration is seen
    wire copy_func = (state == OMC_SELECT) || test_exit; // [RULE_10]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                func_mem[i] <= '0;
            end
        end else if (copy_func) begin
            for (int i = 0; i < DEPTH; i++) begin
                func_mem[i] <= mirror_mem[i]; // [RULE_02] [RULE_10]
            end
        end
    end

    // whole functional configuration exported
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_func
            assign func_cfg[g*WIDTH +: WIDTH] = func_mem[g]; // [RULE_02]
        end
    endgenerate

    // fuse burn walks every mirror word into the next free sector
    // fuses only gain bits here; sector flags are kept outside this block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            burn_sector <= OMC_SECTOR_FIRST;
            fuse_wr_en <= 1'b0;
            fuse_wr_addr <= '0;
            fuse_wr_data <= '0;
        end else begin
            if (burn_go) begin
                burn_sector <= fuse_flags[0] ? OMC_SECTOR_SECOND : OMC_SECTOR_FIRST; // [RULE_05] [RULE_20]
            end
            fuse_wr_en <= (state == OMC_BURN);
            fuse_wr_addr <= {burn_sector, idx};
            fuse_wr_data <= mirror_mem[idx];
        end
    end

    // mode flags
    // several may stand at once; init lasts until software unlocks its exit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= '0;
        end else if (state == OMC_SELECT) begin
            mode.normal <= !diag_s2 && !prog_s2; // [RULE_01]
            mode.diag <= diag_s2 || prog_s2;
            mode.test <= 1'b0;
            mode.prog <= 1'b0;
            mode.init <= 1'b1;
        end else begin
            if (test_enter) begin
                mode.test <= 1'b1; // [RULE_16]
                mode.diag <= 1'b1;
            end else if (test_exit) begin
                mode.test <= 1'b0;
                mode.prog <= 1'b1; // [RULE_17]
            end
            if (prog_exit) begin
                mode.prog <= 1'b0;
                mode.normal <= 1'b1; // [RULE_12] [RULE_17]
                mode.diag <= 1'b1;
                mode.init <= 1'b1;
            end else if (diag_leave) begin
                mode.diag <= 1'b0; // [RULE_18]
                mode.normal <= 1'b1;
            end
            if (init_unlock && !prog_exit) begin
                mode.init <= 1'b0;
            end
        end
    end

    // fail-safe hold; a pending fault wins over a release request
    // outputs start asserted and need a release with no fault pending
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fs_assert <= 1'b1;
        end else if (fault_pending) begin
            fs_assert <= 1'b1; // [RULE_15]
        end else if (safe_release) begin
            fs_assert <= 1'b0; // [RULE_14]
        end
    end

    assign failsafe_output_n = !fs_assert; // [RULE_15]
    assign limp_home_output = fs_assert; // [RULE_15]
endmodule

// >>> tb/omc_fuse_model.sv
// behavioural two-sector fuse array facing the loader
`timescale 1ns/1ps
module omc_fuse_model #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 16
) (
    input wire logic clk,                         // clock
    input wire logic [$clog2(DEPTH):0] rd_addr,   // read {sector, word}
    output logic [WIDTH-1:0] rd_data,             // read data
    input wire logic wr_en,                       // burn strobe
    input wire logic [$clog2(DEPTH):0] wr_addr,   // burn {sector, word}
    input wire logic [WIDTH-1:0] wr_data          // burn data
);
    logic [WIDTH-1:0] mem [2*DEPTH];
    // first sector holds a pattern, second is still blank
    initial begin
        for (int i = 0; i < 2 * DEPTH; i++) begin
            mem[i] = (i < DEPTH) ? WIDTH'(16'hA000 + i) : '0;
        end
    end
    // read is combinational from the address
    assign rd_data = mem[rd_addr];
    // blowing fuses only sets bits
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= mem[wr_addr] | wr_data;
        end
    end
endmodule

// >>> tb/omc_loader_asserts.sv
// port assertions for the fuse mirror loader
`timescale 1ns/1ps
module omc_loader_chk
    import omc_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter logic [31:0] TEST_KEY = omc_pkg::OMC_TEST_KEY_DEF
) (
    input wire logic clk,                              // clock
    input wire logic rst_n,                            // reset, low
    input wire logic psel,                             // apb select
    input wire logic penable,                          // apb access
    input wire logic pwrite,                           // apb write
    input wire logic [omc_pkg::OMC_ADDR_W-1:0] paddr,  // address
    input wire logic [31:0] pwdata,                    // write data
    input wire logic pslverr,                          // apb error
    input wire logic [1:0] fuse_flags,                 // sector flags
    input wire logic [$clog2(DEPTH):0] fuse_rd_addr,   // fuse read address
    input wire logic fuse_wr_en,                       // burn strobe
    input wire logic [$clog2(DEPTH):0] fuse_wr_addr,   // burn address
    input wire logic fault_pending,                    // fault pending
    input wire omc_pkg::omc_mode_t mode,               // modes
    input wire logic failsafe_output_n,                // fail-safe, low
    input wire logic limp_home_output                  // limp-home
);
    localparam int SB = $clog2(DEPTH);
    // write decodes
    wire logic acc_wr = psel && penable && pwrite;
    wire logic wr_sys = acc_wr && paddr == OMC_OFS_SYS_CFG;
    wire logic wr_ctrl = acc_wr && paddr == OMC_OFS_TEST_CTRL;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    fs_hold_a: assert property (fault_pending |=> !failsafe_output_n && limp_home_output)
        else $error("fail-safe released with fault pending");
    mirror_lock_a: assert property (psel && penable && paddr == OMC_OFS_MIRROR_DATA && !mode.test |-> pslverr)
        else $error("mirror access outside test mode");
    burn_refuse_a: assert property (wr_ctrl && pwdata[OMC_BIT_BURN] && fuse_flags == OMC_FLAGS_FULL
        |-> pslverr ##1 !fuse_wr_en [*4]) else $error("burn not refused");
    burn_sector_a: assert property (fuse_wr_en |-> fuse_wr_addr[SB] == fuse_flags[0])
        else $error("burn to wrong sector");
    load_sector_a: assert property ($changed(fuse_rd_addr) && fuse_flags != OMC_FLAGS_NONE
        |-> fuse_rd_addr[SB] == fuse_flags[1]) else $error("load from wrong sector");
    test_entry_a: assert property ($rose(mode.test)
        |-> $past(acc_wr && paddr == OMC_OFS_TEST_KEY && pwdata == TEST_KEY)) else $error("test without key");
    test_exit_a: assert property (wr_ctrl && pwdata[OMC_BIT_TEST_EXIT] && mode.test
        |=> mode.prog && !mode.test) else $error("test exit skipped prog");
    prog_exit_a: assert property (wr_ctrl && pwdata[OMC_BIT_PROG_EXIT] && mode.prog && !mode.test
        |=> mode.normal && mode.diag && mode.init) else $error("prog exit modes wrong");
    diag_stay_a: assert property (mode.diag && !(wr_sys && pwdata[OMC_BIT_DIAG_LEAVE]) |=> mode.diag)
        else $error("diag left without bit");
    diag_leave_a: assert property (wr_sys && pwdata[OMC_BIT_DIAG_LEAVE] && mode.diag
        |=> !mode.diag && mode.normal) else $error("diag leave ignored");
endmodule
bind omc_loader omc_loader_chk #(.DEPTH(DEPTH), .TEST_KEY(TEST_KEY)) u_chk (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .fuse_flags(fuse_flags), .fuse_rd_addr(fuse_rd_addr), .fuse_wr_en(fuse_wr_en), .fuse_wr_addr(fuse_wr_addr),
    .fault_pending(fault_pending), .mode(mode), .failsafe_output_n(failsafe_output_n),
    .limp_home_output(limp_home_output));

// >>> tb/tb_omc_loader.sv
// self-checking bench for the fuse mirror loader
`timescale 1ns/1ps
module tb_omc_loader;
    import omc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pin_diag_level = 1'b0, pin_prog_level = 1'b0, fault_pending = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic [1:0] fuse_flags = 2'h0;
    logic [3:0] fuse_rd_addr, fuse_wr_addr;
    logic [15:0] fuse_rd_data, fuse_wr_data;
    logic [127:0] func_cfg;
    logic pready, pslverr, fuse_wr_en, failsafe_output_n, limp_home_output, rerr;
    omc_mode_t mode;
    int failures = 0, n_tests = 0, cyc = 0;
    always #5 clk = ~clk;
    omc_loader dut (
        .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pin_diag_level, .pin_prog_level, .fuse_flags, .fuse_rd_addr, .fuse_rd_data, .fuse_wr_en,
        .fuse_wr_addr, .fuse_wr_data, .fault_pending, .mode, .func_cfg, .failsafe_output_n, .limp_home_output
    );
    omc_fuse_model fm (.clk(clk), .rd_addr(fuse_rd_addr), .rd_data(fuse_rd_data), .wr_en(fuse_wr_en),
        .wr_addr(fuse_wr_addr), .wr_data(fuse_wr_data));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer, answer taken at the edge where pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic mw(input int i, input logic [31:0] d);
        wr(OMC_OFS_MIRROR_IDX, 32'(i));
        wr(OMC_OFS_MIRROR_DATA, d);
    endtask
    task automatic mfill(input logic [15:0] base);
        for (int i = 0; i < 8; i++) mw(i, 32'(base + 16'(i)));
    endtask
    task automatic mcheck(input logic [15:0] base, input int step);
        for (int i = 0; i < 8; i++) begin
            wr(OMC_OFS_MIRROR_IDX, 32'(i));
            rd(OMC_OFS_MIRROR_DATA);
            chk(rdat, 32'(base + 16'(i * step)), "mirror word");
        end
    endtask
    // power-on with given flags and pin levels, then wait for running
    task automatic boot(input logic [1:0] f, input logic dg, input logic pg);
        @(posedge clk);
        rst_n <= 1'b0;
        fuse_flags <= f;
        pin_diag_level <= dg;
        pin_prog_level <= pg;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdat = 32'h0000_0000;
        for (int i = 0; i < 40 && rdat[5] !== 1'b1; i++) rd(OMC_OFS_STATUS);
    endtask
    task automatic enter();
        wr(OMC_OFS_TEST_KEY, ~OMC_TEST_KEY_DEF);
        chk(32'(mode.test), 32'h0, "bad key");
        wr(OMC_OFS_TEST_KEY, OMC_TEST_KEY_DEF);
        chk(32'(mode), 32'h0000_000D, "test entry");
    endtask
    task automatic t_modes();
        boot(2'h0, 1'b0, 1'b0);
        chk(32'(mode), 32'h0000_0011, "grounded pin");
        wr(OMC_OFS_TEST_KEY, OMC_TEST_KEY_DEF);
        chk(32'(mode.test), 32'h0, "key without pin");
        boot(2'h0, 1'b1, 1'b0);
        chk(32'(mode), 32'h0000_0009, "diag pin");
        @(posedge clk);
        pin_diag_level <= 1'b0;
        repeat (4) @(negedge clk);
        chk(32'(mode.diag), 32'h1, "pin drop");
        wr(OMC_OFS_SYS_CFG, 32'h0000_0001);
        chk(32'(mode), 32'h0000_0011, "diag leave");
        $display("modes done");
    endtask
    task automatic t_load();
        boot(2'h0, 1'b0, 1'b1);
        enter();
        mcheck(16'h0000, 0);
        boot(2'h1, 1'b0, 1'b1);
        enter();
        mcheck(16'hA000, 1);
        $display("load done");
    endtask
    task automatic t_mirror();
        boot(2'h1, 1'b0, 1'b1);
        enter();
        mfill(16'h3300);
        mfill(16'h5500);
        mcheck(16'h5500, 1);
        wr(OMC_OFS_TEST_CTRL, 32'h0000_0001);
        chk(32'(mode.prog && !mode.test), 32'h1, "prog after test");
        repeat (2) @(negedge clk);
        for (int i = 0; i < 8; i++) chk(32'(func_cfg[i*16+:16]), 32'(16'h5500 + i), "func word");
        wr(OMC_OFS_TEST_CTRL, 32'h0000_0002);
        chk(32'(mode), 32'h0000_0019, "after exits");
        mw(2, 32'h0000_1234);
        chk(32'(rerr), 32'h1, "late mirror write");
        rd(OMC_OFS_MIRROR_DATA);
        chk(rdat, 32'h0000_0000, "late mirror read");
        rd(OMC_OFS_FUNC_DATA);
        chk(rdat, 32'h0000_5502, "func kept");
        wr(OMC_OFS_SYS_CFG, 32'h0000_0002);
        chk(32'(mode), 32'h0000_0018, "init unlocked");
        $display("mirror done");
    endtask
    task automatic t_burn();
        boot(2'h1, 1'b0, 1'b1);
        enter();
        mfill(16'h7100);
        wr(OMC_OFS_TEST_CTRL, 32'h0000_0004);
        chk(32'(rerr), 32'h0, "burn taken");
        repeat (12) @(negedge clk);
        for (int i = 0; i < 8; i++) chk(32'(fm.mem[8+i]), 32'(16'h7100 + i), "second sector");
        chk(32'(fm.mem[0]), 32'h0000_A000, "first sector kept");
        boot(2'h3, 1'b0, 1'b1);
        enter();
        mcheck(16'h7100, 1);
        wr(OMC_OFS_TEST_CTRL, 32'h0000_0004);
        chk(32'(rerr), 32'h1, "burn refused");
        mw(1, 32'h0000_00EE);
        rd(OMC_OFS_MIRROR_DATA);
        chk(rdat, 32'h0000_00EE, "mirror usable");
        $display("burn done");
    endtask
    task automatic t_safe();
        boot(2'h0, 1'b0, 1'b0);
        @(posedge clk);
        fault_pending <= 1'b1;
        wr(OMC_OFS_SYS_CFG, 32'h0000_0004);
        repeat (2) @(negedge clk);
        chk(32'({failsafe_output_n, limp_home_output}), 32'h1, "held by fault");
        @(posedge clk);
        fault_pending <= 1'b0;
        wr(OMC_OFS_SYS_CFG, 32'h0000_0004);
        repeat (2) @(negedge clk);
        chk(32'({failsafe_output_n, limp_home_output}), 32'h2, "released");
        $display("safe done");
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        t_modes();
        t_load();
        t_mirror();
        t_burn();
        t_safe();
        conclude();
    end
endmodule
